// >>> logic/pal_pkg.sv
// constants and types of the palette access port
package pal_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W = 9;
    localparam int COLOR_W = 18;
    localparam int SLOT_W = 9;
    localparam logic [ADDR_W-1:0] OFS_INDEX = 16'h8370;
    localparam logic [ADDR_W-1:0] OFS_VALUE = 16'h8374;
    localparam logic [IDX_W-1:0] IDX_RESET = 9'h000;
    localparam logic [IDX_W-1:0] IDX_STEP = 9'h001;
    localparam logic [IDX_W-1:0] IDX_STD_LAST = 9'h0FF;
    localparam logic [IDX_W-1:0] IDX_CURSOR0 = 9'h100;
    localparam logic [IDX_W-1:0] IDX_CURSOR1 = 9'h101;
    localparam logic [IDX_W-1:0] IDX_OVERSCAN = 9'h104;
    localparam logic [SLOT_W-1:0] SLOT_OVERSCAN = 9'h102;
    localparam int RAM_DEPTH = 259;
    localparam logic [COLOR_W-1:0] COLOR_RESET = 18'h00000;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;
    localparam logic [DATA_W-IDX_W-1:0] INDEX_PAD = 23'h000000;
    localparam logic [DATA_W-COLOR_W-1:0] VALUE_PAD = 14'h0000;

    typedef struct packed {
        logic [IDX_W-1:0] index;
        logic [DATA_W-1:0] rdata;
        logic [COLOR_W-1:0] pix_color;
        logic pix_prev;
        logic hold;
    } pal_state_t;
endpackage

// >>> logic/pal_ram_if.sv
// link between access control and palette storage
`timescale 1ns/1ps
interface pal_ram_if;
    logic [pal_pkg::IDX_W-1:0] a_addr;
    logic a_we;
    logic [pal_pkg::COLOR_W-1:0] a_wdata;
    logic [pal_pkg::COLOR_W-1:0] a_rdata;
    logic [pal_pkg::IDX_W-1:0] b_addr;
    logic [pal_pkg::COLOR_W-1:0] b_rdata;
    modport ctrl (output a_addr, output a_we, output a_wdata, input a_rdata,
                  output b_addr, input b_rdata);
    modport ram (input a_addr, input a_we, input a_wdata, output a_rdata,
                 input b_addr, output b_rdata);
endinterface

// >>> logic/pal_ram.sv
// palette storage: standard colours, cursor colours, overscan colour
`timescale 1ns/1ps
module pal_ram (
    input wire logic clk_sys,
    pal_ram_if.ram port
);
    import pal_pkg::*;

    logic [COLOR_W-1:0] mem [0:RAM_DEPTH-1];

    // index to storage slot; reserved and invalid indexes have no slot
    function automatic logic [SLOT_W:0] slot_of(input logic [IDX_W-1:0] idx);
        logic [SLOT_W:0] r;
        r = {1'b0, SLOT_W'(0)};
        if (idx <= IDX_STD_LAST) begin
            r = {1'b1, idx};
        end else if (idx == IDX_CURSOR0 || idx == IDX_CURSOR1) begin
            r = {1'b1, idx};
        end else if (idx == IDX_OVERSCAN) begin
            r = {1'b1, SLOT_OVERSCAN};
        end
        return r;
    endfunction

    logic [SLOT_W:0] a_slot;
    logic [SLOT_W:0] b_slot;

    assign a_slot = slot_of(port.a_addr);
    assign b_slot = slot_of(port.b_addr);
    assign port.a_rdata = a_slot[SLOT_W] ? mem[a_slot[SLOT_W-1:0]] : COLOR_RESET;
    assign port.b_rdata = b_slot[SLOT_W] ? mem[b_slot[SLOT_W-1:0]] : COLOR_RESET;

    always_ff @(posedge clk_sys) begin
        if (port.a_we && a_slot[SLOT_W]) begin
            mem[a_slot[SLOT_W-1:0]] <= port.a_wdata;
        end
    end
endmodule

// >>> logic/pal_access.sv
// palette index/value register pair with glitch-free pixel output
`timescale 1ns/1ps
module pal_access (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [pal_pkg::ADDR_W-1:0] addr,
    input wire logic [pal_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [pal_pkg::DATA_W-1:0] rdata,
    input wire logic pixel_clock,
    input wire logic [pal_pkg::IDX_W-1:0] pixel_sel,
    output logic [pal_pkg::COLOR_W-1:0] pixel_color
);
    import pal_pkg::*;

    pal_state_t st;
    pal_state_t next_st;

    pal_ram_if ram_bus ();

    pal_ram u_ram (
        .clk_sys(clk_sys),
        .port(ram_bus.ram)
    );

    logic hit_index;
    logic hit_value;
    logic value_access;
    logic pix_edge;

    assign hit_index = (addr == OFS_INDEX);
    assign hit_value = (addr == OFS_VALUE);
    assign value_access = hit_value && (wr || rd);
    assign pix_edge = pixel_clock && !st.pix_prev;

    // storage port driven straight from the current index
    assign ram_bus.a_addr = st.index;
    assign ram_bus.a_we = wr && hit_value;
    assign ram_bus.a_wdata = wdata[COLOR_W-1:0];
    assign ram_bus.b_addr = pixel_sel;

    always_comb begin
        next_st = st;
        next_st.rdata = RDATA_RESET;
        next_st.pix_prev = pixel_clock;
        if (wr && hit_index) begin
            next_st.index = wdata[IDX_W-1:0];
        end else if (value_access) begin
            next_st.index = st.index + IDX_STEP;
        end
        if (rd) begin
            if (hit_index) begin
                next_st.rdata = {INDEX_PAD, st.index};
            end else if (hit_value) begin
                next_st.rdata = {VALUE_PAD, ram_bus.a_rdata};
            end
        end
        // pixel edge consumes a pending hold; a new value access re-arms it
        if (pix_edge) begin
            if (st.hold) begin
                next_st.hold = 1'b0;
            end else begin
                next_st.pix_color = ram_bus.b_rdata;
            end
        end
        if (value_access) begin
            next_st.hold = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '{index: IDX_RESET, rdata: RDATA_RESET, pix_color: COLOR_RESET,
                    pix_prev: 1'b0, hold: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign pixel_color = st.pix_color;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_wr_value;
        wr && hit_value;
    endsequence

    sequence s_rd_value;
        rd && hit_value;
    endsequence

    sequence s_reload_prev;
        wr && hit_index && (wdata[IDX_W-1:0] == $past(st.index));
    endsequence

    // one idle bus cycle between two strobes
    sequence s_bus_quiet;
        !wr && !rd;
    endsequence

    sequence s_pix_hold;
        pix_edge && st.hold;
    endsequence

    sequence s_pix_live;
        pix_edge && !st.hold;
    endsequence

    sequence s_load_index;
        wr && hit_index;
    endsequence

    function automatic logic idx_valid(input logic [IDX_W-1:0] idx);
        return (idx <= IDX_STD_LAST) || (idx == IDX_CURSOR0) || (idx == IDX_CURSOR1)
            || (idx == IDX_OVERSCAN);
    endfunction

    AST_INC_ON_WRITE: assert property (s_wr_value |=> st.index == $past(st.index) + IDX_STEP)
        else $error("index did not advance after value write");

    AST_INC_ON_READ: assert property (s_rd_value |=> st.index == $past(st.index) + IDX_STEP)
        else $error("index did not advance after value read");

    AST_INDEX_LOAD: assert property (wr && hit_index |=> st.index == $past(wdata[IDX_W-1:0]))
        else $error("index load wrong");

    AST_INDEX_READ: assert property (rd && hit_index |=> rdata == {INDEX_PAD, $past(st.index)})
        else $error("index read back wrong");

    AST_VALUE_UPPER: assert property (s_rd_value |=> rdata[DATA_W-1:COLOR_W] == VALUE_PAD)
        else $error("value upper bits not zero");

    AST_READBACK: assert property ((s_wr_value ##0 idx_valid(st.index)) ##1 s_reload_prev
        ##1 s_rd_value |=> rdata[COLOR_W-1:0] == $past(wdata[COLOR_W-1:0], 3))
        else $error("palette entry did not keep written colour");

    AST_NO_STORE: assert property (s_rd_value ##0 !idx_valid(st.index) |=> rdata == RDATA_RESET)
        else $error("invalid or reserved index returned data");

    AST_HOLD_ARM: assert property (value_access |=> st.hold)
        else $error("access did not arm output hold");

    AST_HOLD_KEEP: assert property (pix_edge && st.hold |=> $stable(pixel_color))
        else $error("pixel output changed during hold");

    AST_PIX_UPDATE: assert property (pix_edge && !st.hold |=> pixel_color == $past(ram_bus.b_rdata))
        else $error("pixel output not updated on pixel edge");

    AST_HOLD_ONE: assert property (pix_edge && st.hold && !value_access |=> !st.hold)
        else $error("hold lasted beyond one pixel period");

    // register-bus checks
    AST_RDATA_IDLE: assert property (!rd |=> rdata == RDATA_RESET)
        else $error("read data not zero outside a read answer");

    AST_UNMAPPED_READ: assert property (rd && !hit_index && !hit_value
        |=> rdata == RDATA_RESET)
        else $error("unmapped read returned data");

    AST_INDEX_STEADY: assert property (!(wr && hit_index) && !value_access
        |=> $stable(st.index))
        else $error("index changed without an access");

    AST_INDEX_UPPER: assert property (rd && hit_index
        |=> rdata[DATA_W-1:IDX_W] == INDEX_PAD)
        else $error("index upper bits not zero");

    AST_INDEX_WRAP: assert property (value_access && (&st.index)
        |=> st.index == IDX_RESET)
        else $error("index did not wrap to zero");

    AST_WRITE_SILENT: assert property (s_wr_value |=> rdata == RDATA_RESET)
        else $error("value write produced read data");

    AST_INDEX_READ_KEEP: assert property (rd && hit_index |=> $stable(st.index))
        else $error("index read moved the index");

    AST_VALUE_PAIR: assert property (s_wr_value ##1 s_bus_quiet ##1 s_wr_value
        |=> st.index == $past(st.index, 3) + IDX_STEP + IDX_STEP)
        else $error("two value writes did not advance the index by two");

    AST_LOAD_THEN_READ: assert property (s_load_index ##1 s_bus_quiet
        ##1 (rd && hit_index) |=> rdata == {INDEX_PAD, $past(wdata[IDX_W-1:0], 3)})
        else $error("loaded index not read back");

    AST_LOAD_THEN_WRITE: assert property (s_load_index ##1 s_bus_quiet ##1 s_wr_value
        |=> st.index == $past(wdata[IDX_W-1:0], 3) + IDX_STEP)
        else $error("first value write after a load did not step the index");

    AST_LOAD_THEN_FETCH: assert property (s_load_index ##1 s_bus_quiet ##1 s_rd_value
        |=> st.index == $past(wdata[IDX_W-1:0], 3) + IDX_STEP)
        else $error("first value read after a load did not step the index");

    // pixel-path checks
    AST_PIX_QUIET: assert property (!pix_edge |=> $stable(pixel_color))
        else $error("pixel output changed between pixel edges");

    AST_HOLD_STEADY: assert property (!pix_edge && !value_access |=> $stable(st.hold))
        else $error("hold flag changed with no edge and no access");

    AST_HOLD_REARM: assert property (s_pix_hold ##0 value_access |=> st.hold)
        else $error("access at a consuming edge did not re-arm hold");

    AST_LIVE_CLEAR: assert property (s_pix_live ##0 !value_access |=> !st.hold)
        else $error("hold set by a live pixel edge");

    AST_INDEX_NO_HOLD: assert property (s_load_index ##0 !st.hold ##0 !pix_edge
        |=> !st.hold)
        else $error("index write armed the pixel hold");

    AST_PIX_INVALID: assert property (s_pix_live ##0 !idx_valid(pixel_sel)
        |=> pixel_color == COLOR_RESET)
        else $error("invalid pixel index showed a colour");
endmodule

// >>> verif/palette_ram_access_port_bench.sv
// self-checking bench of the palette index/value access port
`timescale 1ns/1ps
module palette_ram_access_port_bench;
    import pal_pkg::*;
    logic clk_sys, rst, wr, rd, pixel_clock;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, got;
    logic [IDX_W-1:0] pixel_sel, base;
    logic [COLOR_W-1:0] pixel_color, held, col[8];
    logic [31:0] seed;
    int error_cnt, total_checks;

    pal_access DUT (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pixel_clock(pixel_clock), .pixel_sel(pixel_sel),
        .pixel_color(pixel_color));

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // value read of an entry last written with c; holes read zero
    function automatic logic [DATA_W-1:0] exp_value(logic [IDX_W-1:0] i, logic [COLOR_W-1:0] c);
        if (i <= IDX_STD_LAST || i == IDX_CURSOR0 || i == IDX_CURSOR1 || i == IDX_OVERSCAN)
            return {VALUE_PAD, c};
        return RDATA_RESET;
    endfunction

    task automatic chk(logic [DATA_W-1:0] g, logic [DATA_W-1:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(logic [ADDR_W-1:0] a);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 got = rdata;
    endtask

    // value write, index reload and value read on consecutive cycles
    task automatic wr_back_rd(logic [IDX_W-1:0] i, logic [COLOR_W-1:0] c);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= OFS_VALUE;
        wdata <= {VALUE_PAD, c};
        @(posedge clk_sys);
        addr <= OFS_INDEX;
        wdata <= {INDEX_PAD, i};
        @(posedge clk_sys);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= OFS_VALUE;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 got = rdata;
    endtask

    // one pixel period; with acc a value write lands on the edge cycle
    task automatic pix_edge(logic acc, logic [COLOR_W-1:0] c);
        @(posedge clk_sys);
        pixel_clock <= 1'b1;
        if (acc) begin
            wr <= 1'b1;
            addr <= OFS_VALUE;
            wdata <= {VALUE_PAD, c};
        end
        @(posedge clk_sys);
        wr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        pixel_clock <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        seed = 32'h05C2;
        error_cnt = 0;
        total_checks = 0;
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        pixel_clock = 1'b0;
        addr = 16'h0000;
        wdata = 32'h00000000;
        pixel_sel = IDX_OVERSCAN;
        held = COLOR_RESET;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        rd_reg(OFS_INDEX);
        chk(got, RDATA_RESET);
        $display("test reset done");
        // random standard run, then a run across the standard/extension edge
        for (int r = 0; r < 2; r++) begin
            void'(xs());
            base = (r == 0) ? {1'b0, seed[7:4], 4'h0} : 9'h0FE;
            wr_reg(OFS_INDEX, {seed[31:9], base});
            rd_reg(OFS_INDEX);
            chk(got, {INDEX_PAD, base});
            for (int k = 0; k < 8; k++) begin
                void'(xs());
                col[k] = seed[COLOR_W-1:0];
                wr_reg(OFS_VALUE, seed);
            end
            rd_reg(OFS_INDEX);
            chk(got, {INDEX_PAD, base + 9'h008});
            wr_reg(OFS_INDEX, {INDEX_PAD, base});
            for (int k = 0; k < 8; k++) begin
                rd_reg(OFS_VALUE);
                chk(got, exp_value(base + IDX_W'(k), col[k]));
            end
            $display("test run %0d done", r);
        end
        wr_reg(OFS_INDEX, 32'h000001FF);
        rd_reg(OFS_VALUE);
        chk(got, RDATA_RESET);
        rd_reg(OFS_INDEX);
        chk(got, RDATA_RESET);
        rd_reg(16'h8378);
        chk(got, RDATA_RESET);
        $display("test wrap done");
        // strobes with no gap: write, reload, read back
        wr_reg(OFS_INDEX, {INDEX_PAD, IDX_CURSOR1});
        void'(xs());
        wr_back_rd(IDX_CURSOR1, seed[COLOR_W-1:0]);
        chk(got, exp_value(IDX_CURSOR1, seed[COLOR_W-1:0]));
        $display("test back to back done");
        // pixel output holds one pixel period after each value access
        for (int p = 0; p < 2; p++) begin
            void'(xs());
            wr_reg(OFS_INDEX, {INDEX_PAD, IDX_OVERSCAN});
            wr_reg(OFS_VALUE, {VALUE_PAD, seed[COLOR_W-1:0]});
            pix_edge(1'b0, COLOR_RESET);
            chk({VALUE_PAD, pixel_color}, {VALUE_PAD, held});
            pix_edge(1'b0, COLOR_RESET);
            held = seed[COLOR_W-1:0];
            chk({VALUE_PAD, pixel_color}, {VALUE_PAD, held});
        end
        $display("test pixel hold done");
        // access on a consuming pixel edge re-arms the hold
        void'(xs());
        wr_reg(OFS_INDEX, {INDEX_PAD, IDX_OVERSCAN});
        wr_reg(OFS_VALUE, {VALUE_PAD, COLOR_RESET});
        wr_reg(OFS_INDEX, {INDEX_PAD, IDX_OVERSCAN});
        pix_edge(1'b1, seed[COLOR_W-1:0]);
        chk({VALUE_PAD, pixel_color}, {VALUE_PAD, held});
        pix_edge(1'b0, COLOR_RESET);
        chk({VALUE_PAD, pixel_color}, {VALUE_PAD, held});
        pix_edge(1'b0, COLOR_RESET);
        held = seed[COLOR_W-1:0];
        chk({VALUE_PAD, pixel_color}, {VALUE_PAD, held});
        $display("test pixel rearm done");
        // pixel path on a cursor entry and on a reserved one
        pixel_sel <= IDX_CURSOR0;
        pix_edge(1'b0, COLOR_RESET);
        chk({VALUE_PAD, pixel_color}, {VALUE_PAD, col[2]});
        pixel_sel <= IDX_CURSOR1 + IDX_STEP;
        pix_edge(1'b0, COLOR_RESET);
        chk({VALUE_PAD, pixel_color}, RDATA_RESET);
        $display("test pixel select done");
        tally_and_finish();
    end
endmodule
